// file: common/scss_pkg.sv
// Package for the system clock source select block: map, fields, resets, types
package scss_pkg;

	// ----------------------------------------------------------------
	// Register bus geometry and register offsets
	// ----------------------------------------------------------------
	localparam int          ADDR_W              = 4;
	localparam int          DATA_W              = 8;
	localparam logic [3:0]  ADDR_OSC_CONTROL    = 4'h0;
	localparam logic [3:0]  ADDR_OSC_TUNING     = 4'h1;
	localparam logic [3:0]  ADDR_TIMER1_CONTROL = 4'h2;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int          SCS_LSB             = 0;
	localparam int          INTERNAL_CLOCK_STABLE_FLAG_BIT            = 2;
	localparam int          PRIMARY_CLOCK_RUNNING_FLAG_BIT            = 3;
	localparam int          IRCF_LSB            = 4;
	localparam int          IDLE_ON_SLEEP_SELECT_BIT           = 7;
	localparam int          LOW_FREQ_SOURCE_SELECT_BIT          = 7;
	localparam int          SECONDARY_OSC_ENABLE_BIT         = 3;
	localparam int          SECONDARY_CLOCK_RUNNING_FLAG_BIT           = 6;

	// ----------------------------------------------------------------
	// Reset values and encodings
	// ----------------------------------------------------------------
	localparam logic [1:0]  SCS_RST             = 2'h0;
	localparam logic [2:0]  IRCF_RST            = 3'h4;
	localparam logic        LOW_FREQ_SOURCE_SELECT_RST          = 1'h0;
	localparam logic        IDLE_ON_SLEEP_SELECT_RST           = 1'h0;
	localparam logic        SECONDARY_OSC_ENABLE_RST         = 1'h0;
	localparam logic [1:0]  SCS_SECONDARY       = 2'h1;
	localparam logic [2:0]  IRCF_LOW_FREQ       = 3'h0;
	localparam logic [2:0]  IRCF_FULL_RATE      = 3'h7;
	localparam logic [2:0]  IRCF_HALF_RATE      = 3'h6;
	localparam logic [3:0]  CFG_INTERNAL_A      = 4'h8;
	localparam logic [3:0]  CFG_INTERNAL_B      = 4'h9;

	// ----------------------------------------------------------------
	// Timing counts, in cycles of the clock named
	// ----------------------------------------------------------------
	localparam logic [1:0]  OLD_SRC_CYCLES      = 2'h2;
	localparam logic [1:0]  NEW_SRC_CYCLES      = 2'h3;
	localparam int          LOW_FREQ_DIV        = 256;
	localparam int          OST_CYCLES          = 1024;
	localparam int          INT_STABLE_CYCLES   = 16;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {SRC_PRIMARY, SRC_SECONDARY, SRC_INTERNAL} scss_src_t;
	typedef enum logic [1:0] {ST_RUN, ST_OLD, ST_NEW} scss_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} scss_bus_t;

endpackage : scss_pkg

// file: core/scss_top.sv
// Clock source selection, internal oscillator postscaler and clock status flags
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module scss_top
	import scss_pkg::*;
#(
	parameter int OST_LEN    = OST_CYCLES,
	parameter int STABLE_LEN = INT_STABLE_CYCLES
) (
	input  wire logic              I_CLK_SYS,
	input  wire logic              I_RESET,
	input  wire scss_bus_t         I_BUS,
	input  wire logic [3:0]        I_PRIMARY_OSC_CONFIG,
	input  wire logic              I_PRIMARY_OSC,
	input  wire logic              I_SECONDARY_OSC,
	input  wire logic              I_LOW_POWER_RC_OSC,
	input  wire logic              I_MAIN_INTERNAL_OSC,
	input  wire logic              I_SLEEP_EXEC,
	output logic [DATA_W-1:0]      O_RDATA,
	output logic                   O_DEVICE_CLK,
	output logic                   O_WDT_CLK,
	output logic                   O_SWITCHING,
	output logic                   O_SLEEP_REQ,
	output logic                   O_IDLE_REQ
);

	localparam int OST_W = $clog2(OST_LEN + 1);
	localparam int STB_W = $clog2(STABLE_LEN + 1);
	localparam int PS_W  = $clog2(LOW_FREQ_DIV);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [7:0]              async_in;
	logic [7:0]              sync_in;
	logic [3:0]              cfg;
	logic                    prim_s;
	logic                    sec_s;
	logic                    lprc_s;
	logic                    main_s;

	assign async_in = {I_PRIMARY_OSC_CONFIG, I_MAIN_INTERNAL_OSC, I_LOW_POWER_RC_OSC,
		I_SECONDARY_OSC, I_PRIMARY_OSC};

	// Two flops per pin; the first stage feeds only the second
	genvar g;
	for (g = 0; g < 8; g++) begin : g_sync
		logic meta;
		logic held;
		always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
			if (I_RESET) begin
				meta <= 1'b0;
				held <= 1'b0;
			end else begin
				meta <= async_in[g];
				held <= meta;
			end
		end
		assign sync_in[g] = held;
	end

	assign prim_s = sync_in[0];
	assign sec_s  = sync_in[1];
	assign lprc_s = sync_in[2];
	assign main_s = sync_in[3];
	assign cfg    = sync_in[7:4];

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	logic [1:0]              scs;
	logic [2:0]              ircf;
	logic                    low_freq_source_select;
	logic                    idle_on_sleep_select;
	logic                    secondary_osc_enable;
	logic                    wr_osc;
	logic                    wr_tune;
	logic                    wr_t1;
	logic [1:0]              wr_scs;
	logic                    scs_refused;

	// Address decode and the secondary-select guard
	assign wr_osc      = I_BUS.wr && (I_BUS.addr == ADDR_OSC_CONTROL);
	assign wr_tune     = I_BUS.wr && (I_BUS.addr == ADDR_OSC_TUNING);
	assign wr_t1       = I_BUS.wr && (I_BUS.addr == ADDR_TIMER1_CONTROL);
	assign wr_scs      = I_BUS.wdata[SCS_LSB +: 2];
	assign scs_refused = (wr_scs == SCS_SECONDARY) && !secondary_osc_enable;

	// Control bits; status bits in the written data are dropped
	always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
		if (I_RESET) begin
			scs     <= SCS_RST;
			ircf    <= IRCF_RST;
			low_freq_source_select  <= LOW_FREQ_SOURCE_SELECT_RST;
			idle_on_sleep_select   <= IDLE_ON_SLEEP_SELECT_RST;
			secondary_osc_enable <= SECONDARY_OSC_ENABLE_RST;
		end else begin
			if (wr_osc) begin
				if (!scs_refused) begin
					scs <= wr_scs;
				end
				ircf  <= I_BUS.wdata[IRCF_LSB +: 3];
				idle_on_sleep_select <= I_BUS.wdata[IDLE_ON_SLEEP_SELECT_BIT];
			end
			if (wr_tune) begin
				low_freq_source_select <= I_BUS.wdata[LOW_FREQ_SOURCE_SELECT_BIT];
			end
			if (wr_t1) begin
				secondary_osc_enable <= I_BUS.wdata[SECONDARY_OSC_ENABLE_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// Internal oscillator block and postscaler
	// ----------------------------------------------------------------
	logic [PS_W-1:0]         ps_cnt;
	logic                    main_prev;
	logic                    main_rise;
	logic [2:0]              ps_idx;
	logic                    int_lvl;
	logic                    int_on_lprc;
	logic                    prim_internal;

	// Postscaler taps: code 110 is bit 0 (4 MHz), code 001 is bit 5
	assign main_rise   = main_s && !main_prev;
	assign ps_idx      = IRCF_HALF_RATE - ircf;
	assign int_on_lprc = (ircf == IRCF_LOW_FREQ) && !low_freq_source_select;
	assign int_lvl     = (ircf == IRCF_FULL_RATE) ? main_s :
		(ircf == IRCF_LOW_FREQ) ? (low_freq_source_select ? ps_cnt[PS_W-1] : lprc_s) :
		ps_cnt[ps_idx];
	assign prim_internal = (cfg == CFG_INTERNAL_A) || (cfg == CFG_INTERNAL_B);

	// Free-running divider off the 8 MHz source
	always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
		if (I_RESET) begin
			main_prev <= 1'b0;
			ps_cnt    <= '0;
		end else begin
			main_prev <= main_s;
			if (main_rise) begin
				ps_cnt <= ps_cnt + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Oscillator start-up and stability counters
	// ----------------------------------------------------------------
	logic [OST_W-1:0]        ost_cnt;
	logic [STB_W-1:0]        stb_cnt;
	logic                    prim_prev;
	logic                    ost_done;
	logic                    int_stable;

	assign ost_done   = (ost_cnt == OST_W'(OST_LEN));
	assign int_stable = (stb_cnt == STB_W'(STABLE_LEN));

	// Both saturate; only reset restarts them
	always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
		if (I_RESET) begin
			prim_prev <= 1'b0;
			ost_cnt   <= '0;
			stb_cnt   <= '0;
		end else begin
			prim_prev <= prim_s;
			if (prim_s && !prim_prev && !ost_done) begin
				ost_cnt <= ost_cnt + 1'b1;
			end
			if (main_rise && !int_stable) begin
				stb_cnt <= stb_cnt + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Source switch, counted in falling edges
	// ----------------------------------------------------------------
	scss_state_t             state;
	scss_state_t             next_state;
	scss_src_t               cur_src;
	scss_src_t               tgt_src;
	scss_src_t               req_src;
	logic [2:0]              src_lvl;
	logic [2:0]              src_prev;
	logic [2:0]              src_fall;
	logic [1:0]              edge_cnt;
	logic                    old_fall;
	logic                    new_fall;

	// Source levels by source index
	assign src_lvl[SRC_PRIMARY]   = prim_internal ? int_lvl : prim_s;
	assign src_lvl[SRC_SECONDARY] = sec_s;
	assign src_lvl[SRC_INTERNAL]  = int_lvl;
	assign src_fall = src_prev & ~src_lvl;
	assign old_fall = src_fall[cur_src];
	assign new_fall = src_fall[tgt_src];

	// Requested source from the select field
	assign req_src = scs[1] ? SRC_INTERNAL :
		(scs[0] ? SRC_SECONDARY : SRC_PRIMARY);

	// Counting falling edges keeps the output low through all of ST_NEW; the first ST_RUN cycle takes the old source's level
	always_comb begin
		next_state = state;
		case (state)
			ST_RUN: begin
				if (req_src != cur_src) begin
					next_state = ST_OLD;
				end
			end
			ST_OLD: begin
				if (old_fall && (edge_cnt == OLD_SRC_CYCLES - 2'h1)) begin
					next_state = ST_NEW;
				end
			end
			ST_NEW: begin
				if (new_fall && (edge_cnt == NEW_SRC_CYCLES - 2'h1)) begin
					next_state = ST_RUN;
				end
			end
			default: begin
				next_state = ST_RUN;
			end
		endcase
	end

	// State, edge counter and source registers
	always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
		if (I_RESET) begin
			state    <= ST_RUN;
			cur_src  <= SRC_PRIMARY;
			tgt_src  <= SRC_PRIMARY;
			edge_cnt <= 2'h0;
			src_prev <= 3'h0;
		end else begin
			state    <= next_state;
			src_prev <= src_lvl;
			if (state == ST_RUN) begin
				tgt_src  <= req_src;
				edge_cnt <= 2'h0;
			end else if (next_state != state) begin
				edge_cnt <= 2'h0;
			end else if ((state == ST_OLD && old_fall) || (state == ST_NEW && new_fall)) begin
				edge_cnt <= edge_cnt + 2'h1;
			end
			if (state == ST_NEW && next_state == ST_RUN) begin
				cur_src <= tgt_src;
			end
		end
	end

	// ----------------------------------------------------------------
	// Status flags, hardware-owned
	// ----------------------------------------------------------------
	logic                    running;
	logic                    flag_primary_clock_running_flag;
	logic                    flag_internal_clock_stable_flag;
	logic                    flag_secondary_clock_running_flag;

	// Each flag needs a settled source, and the sources are distinct
	assign running    = (state == ST_RUN);
	assign flag_primary_clock_running_flag  = running && (cur_src == SRC_PRIMARY) && !prim_internal
		&& ost_done;
	assign flag_internal_clock_stable_flag  = running && int_stable && !int_on_lprc
		&& ((cur_src == SRC_INTERNAL) || (cur_src == SRC_PRIMARY && prim_internal));
	assign flag_secondary_clock_running_flag = running && (cur_src == SRC_SECONDARY);

	// ----------------------------------------------------------------
	// Read data, one cycle after the strobe
	// ----------------------------------------------------------------
	logic [DATA_W-1:0]       rd_osc;
	logic [DATA_W-1:0]       rd_tune;
	logic [DATA_W-1:0]       rd_t1;
	logic [DATA_W-1:0]       next_rdata;

	// Flags appear only here; writes never reach them
	always_comb begin
		rd_osc                  = '0;
		rd_osc[SCS_LSB +: 2]    = scs;
		rd_osc[INTERNAL_CLOCK_STABLE_FLAG_BIT]        = flag_internal_clock_stable_flag;
		rd_osc[PRIMARY_CLOCK_RUNNING_FLAG_BIT]        = flag_primary_clock_running_flag;
		rd_osc[IRCF_LSB +: 3]   = ircf;
		rd_osc[IDLE_ON_SLEEP_SELECT_BIT]       = idle_on_sleep_select;
		rd_tune                 = '0;
		rd_tune[LOW_FREQ_SOURCE_SELECT_BIT]     = low_freq_source_select;
		rd_t1                   = '0;
		rd_t1[SECONDARY_OSC_ENABLE_BIT]      = secondary_osc_enable;
		rd_t1[SECONDARY_CLOCK_RUNNING_FLAG_BIT]        = flag_secondary_clock_running_flag;
	end

	assign next_rdata = !I_BUS.rd ? '0 :
		(I_BUS.addr == ADDR_OSC_CONTROL) ? rd_osc :
		(I_BUS.addr == ADDR_OSC_TUNING) ? rd_tune :
		(I_BUS.addr == ADDR_TIMER1_CONTROL) ? rd_t1 : '0;

	// ----------------------------------------------------------------
	// Output flops
	// ----------------------------------------------------------------
	// Device clock is a retimed copy, so it carries one system-clock jitter
	always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
		if (I_RESET) begin
			O_RDATA      <= '0;
			O_DEVICE_CLK <= 1'b0;
			O_WDT_CLK    <= 1'b0;
			O_SWITCHING  <= 1'b0;
			O_SLEEP_REQ  <= 1'b0;
			O_IDLE_REQ   <= 1'b0;
		end else begin
			O_RDATA      <= next_rdata;
			O_DEVICE_CLK <= (next_state != ST_NEW) && src_lvl[cur_src];
			O_WDT_CLK    <= lprc_s;
			O_SWITCHING  <= (next_state != ST_RUN);
			O_SLEEP_REQ  <= I_SLEEP_EXEC && !idle_on_sleep_select;
			O_IDLE_REQ   <= I_SLEEP_EXEC && idle_on_sleep_select;
		end
	end

endmodule : scss_top

`default_nettype wire

// file: tb/scss_top_assertions.sv
// Assertion checker for the system clock source select block
`timescale 1ns/10ps
`default_nettype none
module scss_top_checker
	import scss_pkg::*;
#(
	parameter int OST_LEN    = OST_CYCLES,
	parameter int STABLE_LEN = INT_STABLE_CYCLES
) (
	input  wire logic              I_CLK_SYS,
	input  wire logic              I_RESET,
	input  wire scss_bus_t         I_BUS,
	input  wire logic              I_LOW_POWER_RC_OSC,
	input  wire logic              I_SLEEP_EXEC,
	input  wire logic [DATA_W-1:0] O_RDATA,
	input  wire logic              O_WDT_CLK,
	input  wire logic              O_SWITCHING,
	input  wire logic              O_SLEEP_REQ,
	input  wire logic              O_IDLE_REQ
);
	// ----
	// Shadow of the control bits, kept from bus writes
	// ----
	logic [1:0] scs;
	logic [3:0] upper;
	logic       sec_en;
	wire        wr_ctrl = I_BUS.wr && I_BUS.addr == ADDR_OSC_CONTROL;
	wire        wr_tmr  = I_BUS.wr && I_BUS.addr == ADDR_TIMER1_CONTROL;
	wire        rd_ctrl = I_BUS.rd && I_BUS.addr == ADDR_OSC_CONTROL;
	wire        rd_tmr  = I_BUS.rd && I_BUS.addr == ADDR_TIMER1_CONTROL;
	wire        sec_ok  = I_BUS.wdata[1:0] != SCS_SECONDARY || sec_en;
	// Both internal codes name the same source, so 10 to 11 is no switch
	wire [1:0]  new_src = I_BUS.wdata[1] ? 2'h2 : I_BUS.wdata[1:0];
	wire [1:0]  cur_src = scs[1] ? 2'h2 : scs;

	always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
		if (I_RESET) begin
			scs    <= SCS_RST;
			upper  <= {IDLE_ON_SLEEP_SELECT_RST, IRCF_RST};
			sec_en <= SECONDARY_OSC_ENABLE_RST;
		end else begin
			if (wr_ctrl)
				upper <= I_BUS.wdata[7:4];
			if (wr_ctrl && sec_ok)
				scs <= I_BUS.wdata[1:0];
			if (wr_tmr)
				sec_en <= I_BUS.wdata[SECONDARY_OSC_ENABLE_BIT];
		end
	end

	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (I_RESET);

	ctrl_read_a: assert property (rd_ctrl |=>
		O_RDATA[7:4] == upper && O_RDATA[1:0] == scs) else $error("control readback wrong");
	flag_onehot_a: assert property (rd_ctrl |=>
		!(O_RDATA[INTERNAL_CLOCK_STABLE_FLAG_BIT] && O_RDATA[PRIMARY_CLOCK_RUNNING_FLAG_BIT])) else $error("two running flags set");
	tmr_read_a: assert property (rd_tmr && !O_SWITCHING |=>
		(O_RDATA & 8'hbf) == {4'h0, sec_en, 3'h0} && (!O_RDATA[SECONDARY_CLOCK_RUNNING_FLAG_BIT] || scs == SCS_SECONDARY))
		else $error("timer control readback wrong");
	sleep_choice_a: assert property (I_SLEEP_EXEC |=>
		O_IDLE_REQ == upper[3] && O_SLEEP_REQ == !upper[3]) else $error("wrong sleep mode");
	wdt_source_a: assert property ($rose(I_LOW_POWER_RC_OSC) |-> ##[1:4] O_WDT_CLK)
		else $error("watchdog clock not following low-power source");
	switch_start_a: assert property (wr_ctrl && sec_ok && new_src != cur_src && !O_SWITCHING
		|=> ##[0:2] O_SWITCHING) else $error("source switch not started");
	switch_bound_a: assert property ($rose(O_SWITCHING) |-> ##[1:1000] !O_SWITCHING)
		else $error("source switch never ends");
	no_switch_a: assert property (wr_ctrl && (new_src == cur_src || !sec_ok) && !O_SWITCHING
		|=> !O_SWITCHING [*3]) else $error("switch without source change");
endmodule : scss_top_checker

bind scss_top scss_top_checker #(.OST_LEN(OST_LEN), .STABLE_LEN(STABLE_LEN)) u_checker (
	.I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET), .I_BUS(I_BUS),
	.I_LOW_POWER_RC_OSC(I_LOW_POWER_RC_OSC), .I_SLEEP_EXEC(I_SLEEP_EXEC), .O_RDATA(O_RDATA),
	.O_WDT_CLK(O_WDT_CLK), .O_SWITCHING(O_SWITCHING), .O_SLEEP_REQ(O_SLEEP_REQ),
	.O_IDLE_REQ(O_IDLE_REQ));
`default_nettype wire

// file: tb/tb_system_clock_source_select.sv
// Self-checking bench for the system clock source select block
`timescale 1ns/10ps
`default_nettype none
module tb_system_clock_source_select;
	import scss_pkg::*;
	typedef struct packed {logic [7:0] val; logic [7:0] msk;} scss_note_t;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        slp = 1'b0;
	logic        rd_d = 1'b0;
	logic [7:0]  cnt = 8'h00;
	logic [31:0] rnd = 32'd34;
	scss_bus_t   bus = '0;
	scss_note_t  nq[$];
	scss_note_t  nt;
	wire  [7:0]  rdata;
	wire         sw, sreq, ireq;
	int          n_mismatch = 0;
	int          checks = 0;

	scss_top #(.OST_LEN(4), .STABLE_LEN(2)) dut (
		.I_CLK_SYS(clk), .I_RESET(rst), .I_BUS(bus), .I_PRIMARY_OSC_CONFIG(4'h2),
		.I_PRIMARY_OSC(cnt[2]), .I_SECONDARY_OSC(cnt[4]), .I_LOW_POWER_RC_OSC(cnt[5]),
		.I_MAIN_INTERNAL_OSC(cnt[1]), .I_SLEEP_EXEC(slp), .O_RDATA(rdata),
		.O_DEVICE_CLK(), .O_WDT_CLK(), .O_SWITCHING(sw), .O_SLEEP_REQ(sreq),
		.O_IDLE_REQ(ireq));

	// Clock and oscillators; the secondary runs always, so it is stable when picked
	always #2 clk = ~clk;
	always @(posedge clk) cnt <= cnt + 8'h01;

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs

	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
		nq.push_back('{val: e, msk: m});
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
	endtask : rd

	// Bounded wait for a switch to start and end; sampled mid-cycle to avoid races
	task automatic wait_sw;
		int n = 0;
		while (sw !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		chk(8'(n >= 20), 8'h00);
		while (sw !== 1'b0 && n < 900) begin
			@(negedge clk);
			n++;
		end
		chk(8'(n >= 900), 8'h00);
		@(posedge clk);
	endtask : wait_sw

	task automatic conclude;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude

	// Result watcher: oldest note against each read or sleep answer
	always @(posedge clk) rd_d <= bus.rd;
	always @(negedge clk) begin
		if (rd_d || sreq || ireq) begin
			nt = nq.pop_front();
			chk((rd_d ? rdata : {6'h00, ireq, sreq}) & nt.msk, nt.val & nt.msk);
		end
	end

	initial begin
		#200000;
		n_mismatch++;
		conclude();
	end

	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(ADDR_OSC_CONTROL, 8'h40, 8'hf3);
		rd(ADDR_TIMER1_CONTROL, 8'h00, 8'hff);
		wr(4'h9, 8'hff);
		rd(4'h9, 8'h00, 8'hff);
		wr(ADDR_OSC_CONTROL, 8'h41);
		rd(ADDR_OSC_CONTROL, 8'h40, 8'hff);
		wr(ADDR_TIMER1_CONTROL, 8'hff);
		rd(ADDR_TIMER1_CONTROL, 8'h08, 8'hff);
		wr(ADDR_OSC_TUNING, 8'hff);
		rd(ADDR_OSC_TUNING, 8'h80, 8'hff);
		wr(ADDR_OSC_CONTROL, 8'h41);
		wait_sw();
		rd(ADDR_TIMER1_CONTROL, 8'h48, 8'hff);
		rd(ADDR_OSC_CONTROL, 8'h41, 8'hff);
		wr(ADDR_OSC_CONTROL, 8'h72);
		wait_sw();
		repeat (20) @(posedge clk);
		rd(ADDR_OSC_CONTROL, 8'h76, 8'hff);
		rd(ADDR_TIMER1_CONTROL, 8'h08, 8'hff);
		// Every frequency code on the running internal clock, random idle bit
		for (int i = 0; i < 8; i++) begin
			rnd = xs(rnd);
			wr(ADDR_OSC_CONTROL, {rnd[0], 3'(i), 4'h2});
			@(negedge clk);
			chk({7'h00, sw}, 8'h00);
			@(posedge clk);
			rd(ADDR_OSC_CONTROL, {rnd[0], 3'(i), 4'h2}, 8'hf3);
		end
		for (int k = 0; k < 2; k++) begin
			wr(ADDR_OSC_CONTROL, {k[0], 7'h72});
			nq.push_back('{val: {6'h00, k[0], !k[0]}, msk: 8'h03});
			slp <= 1'b1;
			@(posedge clk);
			slp <= 1'b0;
			repeat (2) @(posedge clk);
		end
		wr(ADDR_OSC_CONTROL, 8'h70);
		wait_sw();
		repeat (60) @(posedge clk);
		rd(ADDR_OSC_CONTROL, 8'h78, 8'hff);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(ADDR_OSC_CONTROL, 8'h40, 8'hf3);
		rd(ADDR_OSC_TUNING, 8'h00, 8'hff);
		repeat (4) @(posedge clk);
		chk(8'(nq.size()), 8'h00);
		conclude();
	end
endmodule : tb_system_clock_source_select
`default_nettype wire
